/* hdl/vic_pkg.sv */
// Constants shared by the vectored interrupt controller.
// Assumes a single system clock and a 24-bit program word address space.
package vic_pkg;

    // Source counts and packing of the flag, enable and priority words.
    localparam int NUM_TRAP = 6;
    localparam int NUM_IRQ = 246;
    localparam int WORD_BITS = 16;
    localparam int NUM_FLAG_REGS = 16;
    localparam int FLAG_BITS = NUM_FLAG_REGS * WORD_BITS;
    localparam int PRIO_PER_REG = 4;
    localparam int PRIO_FIELD_STEP = 4;
    localparam int NUM_PRIO_REGS = 62;
    localparam int PRIO_BITS = NUM_PRIO_REGS * WORD_BITS;
    localparam int LVL_W = 3;

    // Request number plus this offset is the vector number.
    localparam logic [7:0] IRQ_VEC_OFFSET = 8'h08;

    // Table layout in program words.
    localparam logic [23:0] PRI_TABLE_BASE = 24'h000004;
    localparam logic [23:0] RESET_ADDR = 24'h000000;
    localparam logic [23:0] PAGE_WORDS = 24'h000800;
    localparam logic [12:0] BS_MIN_PAGES = 13'h0002;

    // Requests 21 to 23 have no flag, enable or priority bits.
    localparam logic [FLAG_BITS-1:0] IMPL_MASK =
        {{(FLAG_BITS-NUM_IRQ){1'b0}}, {(NUM_IRQ-24){1'b1}},
         3'h0, {21{1'b1}}};

    // Level reported to the core while a trap is presented.
    localparam logic [LVL_W-1:0] TRAP_LEVEL = 3'h7;

    // Vector fetch sequence.
    typedef enum logic [1:0] {
        VIC_IDLE,
        VIC_FETCH,
        VIC_LOAD
    } vic_state_t;

endpackage

/* hdl/vic_top.sv */
// Vectored interrupt controller: flags, arbitration and vector fetch.
// Assumes peripherals and the core share sys_clk; the program memory
// returns fetch_data one cycle after fetch_en_r.
`timescale 1ns/1ps
`default_nettype none

module vic_top
    import vic_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Peripheral event pulses and software flag control.
    input wire logic [FLAG_BITS-1:0] periph_req,
    input wire logic [FLAG_BITS-1:0] flag_clr,
    input wire logic [NUM_TRAP-1:0] trap_req,
    // Enable and priority words.
    input wire logic [FLAG_BITS-1:0] en_words,
    input wire logic [PRIO_BITS-1:0] prio_words,
    // Alternate table controls.
    input wire logic alt_table_enable,
    input wire logic alt_table_config_disable,
    input wire logic bs_defined,
    input wire logic [12:0] boot_segment_limit,
    input wire logic bs_protect,
    // Core side.
    input wire logic [LVL_W-1:0] cpu_ipl,
    input wire logic irq_ack,
    output logic irq_req_r,
    output logic irq_is_trap_r,
    output logic [7:0] irq_vec_r,
    output logic [LVL_W-1:0] irq_level_r,
    output logic [23:0] handler_addr_r,
    output logic handler_valid_r,
    // Program memory fetch port.
    input wire logic [23:0] fetch_data,
    output logic fetch_en_r,
    output logic [23:0] fetch_addr_r,
    output logic fetch_prot_r,
    // Status.
    output logic [FLAG_BITS-1:0] flag_words,
    output logic alt_active_r
);

    // Sticky flags and their next value.
    logic [FLAG_BITS-1:0] flag_r;
    logic [FLAG_BITS-1:0] flag_nxt;
    // Pending traps and their next value.
    logic [NUM_TRAP-1:0] trap_r;
    logic [NUM_TRAP-1:0] trap_nxt;
    // Trap bit cleared by the acknowledge of a presented trap.
    logic [NUM_TRAP-1:0] trap_clr;
    // Fetch sequence state.
    vic_state_t state_r;
    // Per-source level and live flag.
    logic [LVL_W-1:0] src_lvl [NUM_IRQ];
    logic [NUM_IRQ-1:0] src_live;
    // Arbitration result.
    logic [7:0] best_irq;
    logic [LVL_W-1:0] best_lvl;
    logic best_found;
    logic [2:0] trap_idx;
    logic trap_any;
    // Selected request for the core.
    logic sel_req;
    logic [7:0] sel_vec;
    logic [LVL_W-1:0] sel_lvl;
    // Table addressing.
    logic [23:0] bs_ext;
    logic [23:0] alt_base;
    logic [23:0] vec_off;
    logic [23:0] vec_addr;
    logic alt_nxt;
    logic take;

    // Set wins over clear; reserved bits never hold a flag.
    assign flag_nxt = ((flag_r & ~flag_clr) | periph_req)
        & IMPL_MASK;
    // An acknowledged trap stays pending when it is raised again in the
    // same cycle, so a fresh trap is never lost.
    assign trap_clr = (take & irq_is_trap_r)
        ? (6'h01 << irq_vec_r[2:0]) : 6'h00;
    assign trap_nxt = (trap_r & ~trap_clr) | trap_req;

    // Level and eligibility of each source, from the packed words.
    genvar g;
    generate
        for (g = 0; g < NUM_IRQ; g++) begin : g_src
            assign src_lvl[g] = prio_words[(g / PRIO_PER_REG) * WORD_BITS
                + (g % PRIO_PER_REG) * PRIO_FIELD_STEP +: LVL_W];
            assign src_live[g] = flag_r[g] & en_words[g] & IMPL_MASK[g]
                & (src_lvl[g] != 3'h0);
        end
    endgenerate

    // Highest level wins; scanning downward lets the lowest number
    // take a tie.
    always_comb begin
        best_irq = 8'h00;
        best_lvl = 3'h0;
        best_found = 1'b0;
        for (int n = NUM_IRQ - 1; n >= 0; n--) begin
            if (src_live[n] && src_lvl[n] >= best_lvl) begin
                best_irq = 8'(n);
                best_lvl = src_lvl[n];
                best_found = 1'b1;
            end
        end
    end

    // Lowest pending trap; traps sit at the lowest vectors.
    always_comb begin
        trap_idx = 3'h0;
        trap_any = 1'b0;
        for (int t = NUM_TRAP - 1; t >= 0; t--) begin
            if (trap_r[t]) begin
                trap_idx = 3'(t);
                trap_any = 1'b1;
            end
        end
    end

    // Traps are non-maskable; interrupts must beat the core level.
    assign sel_req = trap_any | (best_found & (best_lvl > cpu_ipl));
    assign sel_vec = trap_any ? {5'h00, trap_idx}
                              : best_irq + IRQ_VEC_OFFSET;
    assign sel_lvl = trap_any ? TRAP_LEVEL : best_lvl;

    // Alternate table only with segment, config bit and enable.
    assign alt_nxt = bs_defined & alt_table_config_disable
        & alt_table_enable;
    assign bs_ext = {11'h000, boot_segment_limit};
    assign alt_base = 24'((bs_ext - 24'h000001) * PAGE_WORDS);
    assign vec_off = {15'h0000, irq_vec_r, 1'b0};
    assign vec_addr = (alt_active_r ? alt_base : RESET_ADDR)
        + PRI_TABLE_BASE + vec_off;
    assign take = (state_r == VIC_IDLE) & irq_req_r & irq_ack;

    // Flags, traps and the alternate table selection.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flag_r <= '0;
            trap_r <= '0;
            alt_active_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            trap_r <= trap_nxt;
            alt_active_r <= alt_nxt;
        end
    end

    assign flag_words = flag_r;

    // Presented request; dropped while a vector is fetched, vector and level held.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_req_r <= 1'b0;
            irq_is_trap_r <= 1'b0;
            irq_vec_r <= 8'h00;
            irq_level_r <= 3'h0;
        end else if (state_r == VIC_IDLE && !take) begin
            irq_req_r <= sel_req;
            irq_is_trap_r <= trap_any;
            irq_vec_r <= sel_vec;
            irq_level_r <= sel_lvl;
        end else begin
            irq_req_r <= 1'b0;
        end
    end

    // Fixed three-step fetch: ack, address out, data captured.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= VIC_IDLE;
            fetch_en_r <= 1'b0;
            fetch_addr_r <= 24'h000000;
            fetch_prot_r <= 1'b0;
            handler_addr_r <= 24'h000000;
            handler_valid_r <= 1'b0;
        end else begin
            fetch_en_r <= 1'b0;
            handler_valid_r <= 1'b0;
            case (state_r)
                VIC_IDLE: begin
                    if (take) begin
                        state_r <= VIC_FETCH;
                        fetch_en_r <= 1'b1;
                        fetch_addr_r <= vec_addr;
                        fetch_prot_r <= bs_protect;
                    end
                end
                VIC_FETCH: begin
                    state_r <= VIC_LOAD;
                end
                VIC_LOAD: begin
                    handler_addr_r <= fetch_data;
                    handler_valid_r <= 1'b1;
                    state_r <= VIC_IDLE;
                end
                default: begin
                    state_r <= VIC_IDLE;
                end
            endcase
        end
    end

    // A pulse on request 0 always leaves its flag set.
    chk_flag_set_wins: assert property (
        @(posedge sys_clk) disable iff (rst)
        periph_req[0] |=> flag_words[0])
        else $error("flag lost on set");

    // Reserved requests never show a flag.
    chk_reserved_flags: assert property (
        @(posedge sys_clk) disable iff (rst)
        flag_words[23:21] == 3'h0)
        else $error("reserved flag set");

    // Acknowledge to handler address takes exactly three cycles.
    chk_fixed_entry: assert property (
        @(posedge sys_clk) disable iff (rst)
        take |=> fetch_en_r ##1 !fetch_en_r ##1 handler_valid_r)
        else $error("entry latency wrong");

    // Primary addresses follow base plus two words per vector.
    chk_primary_addr: assert property (
        @(posedge sys_clk) disable iff (rst)
        fetch_en_r && !$past(alt_active_r) |->
        fetch_addr_r == PRI_TABLE_BASE + {15'h0000, irq_vec_r, 1'b0})
        else $error("primary address wrong");

    // Alternate table only after all three conditions held.
    chk_alt_gate: assert property (
        @(posedge sys_clk) disable iff (rst)
        alt_active_r |-> $past(alt_table_enable) && $past(bs_defined)
        && $past(alt_table_config_disable))
        else $error("alternate table without enable");

    // Interrupt requests carry a nonzero level and a vector at or above IRQ_VEC_OFFSET.
    chk_level_live: assert property (
        @(posedge sys_clk) disable iff (rst)
        irq_req_r && !irq_is_trap_r |->
        irq_level_r != 3'h0 && irq_vec_r >= IRQ_VEC_OFFSET)
        else $error("request level or vector wrong");

    // Handler address is the word returned by the fetch.
    chk_handler_word: assert property (
        @(posedge sys_clk) disable iff (rst)
        handler_valid_r |-> handler_addr_r == $past(fetch_data))
        else $error("handler address wrong");

    // Fetches inherit boot segment protection.
    chk_fetch_prot: assert property (
        @(posedge sys_clk) disable iff (rst)
        take |=> fetch_prot_r == $past(bs_protect))
        else $error("fetch protection wrong");

    // After reset nothing is requested or fetched.
    chk_reset_idle: assert property (
        @(posedge sys_clk)
        $past(rst) |-> !irq_req_r && !fetch_en_r && flag_words == '0)
        else $error("activity out of reset");

    // A trap request is held even when its ack falls in the same cycle.
    chk_trap_set_wins: assert property (
        @(posedge sys_clk) disable iff (rst)
        trap_req != 6'h00 |=>
        (trap_r & $past(trap_req)) == $past(trap_req))
        else $error("trap request lost");

    // A pending trap is presented ahead of every interrupt.
    chk_trap_ahead: assert property (
        @(posedge sys_clk) disable iff (rst)
        state_r == VIC_IDLE && !take && trap_r != 6'h00 |=>
        irq_req_r && irq_is_trap_r)
        else $error("trap not presented first");

    // Alternate fetches sit in the last page of the boot segment.
    chk_alt_addr: assert property (
        @(posedge sys_clk) disable iff (rst)
        fetch_en_r && $past(alt_active_r) |->
        fetch_addr_r == ({11'h000, $past(boot_segment_limit)}
        - 24'h000001) * PAGE_WORDS + PRI_TABLE_BASE
        + {15'h0000, irq_vec_r, 1'b0})
        else $error("alternate address wrong");

endmodule

`default_nettype wire

/* verification/vic_core_model.sv */
// Core and program memory model facing the interrupt controller.
// Assumes the controller's outputs change on the shared sys_clk.
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
    // Clock.
    input wire logic sys_clk,
    // Controller side.
    input wire logic irq_req_r,
    input wire logic fetch_en_r,
    input wire logic [23:0] fetch_addr_r,
    // Extra cycles the core lets a request wait.
    input wire logic [3:0] ack_wait,
    output logic irq_ack,
    output logic [23:0] fetch_data
);
    logic [3:0] wait_r = 4'h0; // Cycles the request has waited.
    initial irq_ack = 1'b0;
    initial fetch_data = 24'h000000;
    // One ack pulse per request, one cycle long, once the request has waited ack_wait cycles.
    // Memory answers one cycle after the strobe and toggles otherwise.
    always @(posedge sys_clk) begin
        wait_r <= #1 (irq_req_r && !irq_ack) ? wait_r + 4'h1 : 4'h0;
        irq_ack <= #1 irq_req_r && !irq_ack && (wait_r >= ack_wait);
        // Every vector location, used or not, holds a handler word.
        fetch_data <= #1 fetch_en_r ? (fetch_addr_r ^ 24'ha5a5a5)
            : ~fetch_data;
    end
endmodule
`default_nettype wire

/* verification/test_vic_top.sv */
// Self-checking bench for the vectored interrupt controller.
// Assumes vic_pkg and vic_top are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_vic_top;
    import vic_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1;
    logic [FLAG_BITS-1:0] periph_req = '0, flag_clr = '0, en_words = '0;
    logic [PRIO_BITS-1:0] prio_words = '0;
    logic [NUM_TRAP-1:0] trap_req = '0;
    logic alt_table_enable = 1'b0, alt_table_config_disable = 1'b0;
    logic bs_defined = 1'b0, bs_protect = 1'b0, irq_ack;
    // Boot segment of three pages, above the two-page minimum.
    logic [12:0] boot_segment_limit = 13'h0003;
    logic [2:0] cpu_ipl = 3'h7, irq_level_r;
    logic [3:0] ack_wait = 4'h0;
    logic irq_req_r, irq_is_trap_r, handler_valid_r, fetch_en_r;
    logic fetch_prot_r, alt_active_r;
    logic [7:0] irq_vec_r;
    logic [23:0] handler_addr_r, fetch_data, fetch_addr_r;
    logic [FLAG_BITS-1:0] flag_words;
    int mismatches = 0, tests_run = 0;

    always #5 sys_clk = ~sys_clk;

    vic_top uut (.sys_clk(sys_clk), .rst(rst), .periph_req(periph_req),
        .flag_clr(flag_clr), .trap_req(trap_req), .en_words(en_words),
        .prio_words(prio_words), .alt_table_enable(alt_table_enable),
        .alt_table_config_disable(alt_table_config_disable),
        .bs_defined(bs_defined), .boot_segment_limit(boot_segment_limit),
        .bs_protect(bs_protect), .cpu_ipl(cpu_ipl), .irq_ack(irq_ack),
        .irq_req_r(irq_req_r), .irq_is_trap_r(irq_is_trap_r),
        .irq_vec_r(irq_vec_r), .irq_level_r(irq_level_r),
        .handler_addr_r(handler_addr_r), .handler_valid_r(handler_valid_r),
        .fetch_data(fetch_data), .fetch_en_r(fetch_en_r),
        .fetch_addr_r(fetch_addr_r), .fetch_prot_r(fetch_prot_r),
        .flag_words(flag_words), .alt_active_r(alt_active_r));
    vic_core_model core (.sys_clk(sys_clk), .irq_req_r(irq_req_r),
        .fetch_en_r(fetch_en_r), .fetch_addr_r(fetch_addr_r),
        .ack_wait(ack_wait), .irq_ack(irq_ack), .fetch_data(fetch_data));

    // Inputs move 1 ns after the rising edge.
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic report_and_stop;
        if (mismatches == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [23:0] exp,
                         input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait on the request (sel 0) or the fetch strobe (sel 1).
    task automatic wait_for(input int sel);
        int k;
        k = 0;
        while (((sel == 1) ? fetch_en_r : irq_req_r) !== 1'b1) begin
            tick(1);
            k++;
            if (k > 60) begin
                mismatches++;
                report_and_stop();
            end
        end
    endtask

    // Sets level and enable of request n, then pulses its event.
    task automatic raise(input int n, input logic [2:0] lvl);
        prio_words[(n/4)*16+(n%4)*4 +: 3] = lvl;
        en_words[n] = 1'b1;
        periph_req[n] = 1'b1;
        tick(1);
        periph_req[n] = 1'b0;
    endtask

    task automatic clear(input int n);
        flag_clr[n] = 1'b1;
        tick(1);
        flag_clr[n] = 1'b0;
    endtask

    // Lets the core take one request and checks the whole entry.
    // Leaves cpu_ipl at 7 so a still-set flag is not presented again.
    task automatic serve(input logic [7:0] vec, input logic [23:0] base,
                         input logic [2:0] lvl, input logic trap);
        logic [23:0] a;
        a = base + 24'h000004 + {15'h0, vec, 1'b0};
        cpu_ipl = 3'h0;
        wait_for(0);
        check("vector", {16'h0, vec}, {16'h0, irq_vec_r});
        check("trap", {23'h0, trap}, {23'h0, irq_is_trap_r});
        check("level", {21'h0, lvl}, {21'h0, irq_level_r});
        wait_for(1);
        check("fetch addr", a, fetch_addr_r);
        check("prot", {23'h0, bs_protect}, {23'h0, fetch_prot_r});
        tick(2);
        check("valid", 24'h1, {23'h0, handler_valid_r});
        check("handler", a ^ 24'ha5a5a5, handler_addr_r);
        cpu_ipl = 3'h7;
    endtask

    initial begin
        tick(20);
        rst = 1'b0;
        check("idle req", 24'h0, {23'h0, irq_req_r});
        check("idle handler", 24'h0, handler_addr_r);
        // Level 0 and reserved requests never reach the core.
        raise(15, 3'h0);
        raise(21, 3'h5);
        cpu_ipl = 3'h0;
        tick(3);
        check("flag15", 24'h1, {23'h0, flag_words[15]});
        check("flag21", 24'h0, {23'h0, flag_words[21]});
        check("no req", 24'h0, {23'h0, irq_req_r});
        cpu_ipl = 3'h7;
        clear(15);
        // Equal levels: lower request wins, the core answers slowly.
        ack_wait = 4'h9;
        raise(24, 3'h4);
        raise(13, 3'h4);
        tick(2);
        check("masked", 24'h0, {23'h0, irq_req_r});
        serve(8'd21, 24'h0, 3'h4, 1'b0);
        ack_wait = 4'h0;
        clear(13);
        serve(8'd32, 24'h0, 3'h4, 1'b0);
        clear(24);
        // A higher level beats a lower request number.
        raise(5, 3'h2);
        raise(40, 3'h6);
        serve(8'd48, 24'h0, 3'h6, 1'b0);
        clear(40);
        serve(8'd13, 24'h0, 3'h2, 1'b0);
        clear(5);
        // A trap beats a pending level 7 source.
        raise(0, 3'h7);
        trap_req[2] = 1'b1;
        tick(1);
        trap_req[2] = 1'b0;
        serve(8'd2, 24'h0, 3'h7, 1'b1);
        serve(8'd8, 24'h0, 3'h7, 1'b0);
        clear(0);
        // Only all three alternate conditions move the table.
        for (int i = 0; i < 4; i++) begin
            alt_table_enable = (i != 0);
            alt_table_config_disable = (i != 1);
            bs_defined = (i != 2);
            bs_protect = i[0];
            raise(1, 3'h1);
            check("alt", {23'h0, i == 3}, {23'h0, alt_active_r});
            serve(8'd9, (i == 3) ? 24'h001000 : 24'h0, 3'h1, 1'b0);
            clear(1);
        end
        trap_req[0] = 1'b1;
        tick(1);
        trap_req[0] = 1'b0;
        serve(8'd0, 24'h001000, 3'h7, 1'b1);
        // A set and a clear in the same cycle leave the flag set.
        periph_req[7] = 1'b1;
        flag_clr[7] = 1'b1;
        tick(1);
        periph_req[7] = 1'b0;
        flag_clr[7] = 1'b0;
        check("set wins", 24'h1, {23'h0, flag_words[7]});
        // A reset in mid-run clears flags and outputs.
        raise(3, 3'h2);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        check("rst flags", 24'h0, {23'h0, |flag_words});
        check("rst handler", 24'h0, handler_addr_r);
        check("rst alt", 24'h0, {23'h0, alt_active_r});
        tick(1);
        check("alt again", 24'h1, {23'h0, alt_active_r});
        report_and_stop();
    end
endmodule
`default_nettype wire
